// *** rtl/sscd_led_drive.sv ***
`include "sscd_params.svh"
// One strap-shared LED pin: the latched strap sets which level lights it.
module sscd_led_drive (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic drive_en,
  input  wire logic strap_val,
  input  wire logic led_on,
  output logic      pin_o,
  output logic      pin_oe
);
  logic pin_q;
  logic pin_d;
  logic oe_q;
  logic oe_d;

  always_comb begin
    // Latched 1 lights by pulling low, latched 0 by driving high
    pin_d = strap_val ? ~led_on : led_on;
    oe_d  = drive_en;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
    end else if (clk_en) begin
      pin_q <= pin_d;
      oe_q  <= oe_d;
    end
  end

  assign pin_o  = pin_q;
  assign pin_oe = oe_q;
endmodule

// *** rtl/sscd_strap_decode.sv ***
`include "sscd_params.svh"
// How it works
// - Ports 1 and 2 each have a strap enabling auto crossover.
// - Strap selects EEPROM addressing: 4Kx8 and larger, or 2Kx8 and smaller.
// - Management straps: 01 SMI, 10 I2C default, 00 and 11 reserved.
// - Address strap 0 gives 0,1,2; strap 1 gives 1,2,3.
// - Port 0 mode strap decodes MII/turbo/RMII variants; 111 reserved.
// - Duplex polarity strap sets which pin level means full duplex.
// - Port 0 mode inputs pulled up internally; undriven reads as 1.
// - LED function 00b shows duplex/collision, link/activity, speed.
// - Straps sampled at power-up and each rising edge of external reset.
// - Strap-shared LED pins drive low-active for 1, high-active for 0.
// - Management master or EEPROM may overwrite latched strap defaults.
module sscd_strap_decode (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       ext_reset_n,
  input  wire logic       xover_p1_strap,
  input  wire logic       xover_p2_strap,
  input  wire logic       eeprom_size_strap,
  input  wire logic       mgmt_sel_lo,
  input  wire logic       mgmt_sel_hi,
  input  wire logic       port_id_offset_strap,
  input  wire logic [2:0] port0_iface_sel,
  input  wire logic [2:0] port0_iface_sel_drv,
  input  wire logic       port0_duplex_polarity_strap,
  input  wire logic       port0_duplex_polarity_drv,
  input  wire logic       port0_duplex_pin,
  input  wire logic       ovr_we,
  input  wire logic [1:0] ovr_xover,
  input  wire logic       ovr_eeprom_large,
  input  wire logic [1:0] ovr_mgmt,
  input  wire logic       ovr_addr_off,
  input  wire logic [2:0] ovr_port0_iface_sel,
  input  wire logic       ovr_dup_pol,
  input  wire logic [1:0] led_function_sel,
  input  wire logic [5:0] led_status,
  output logic            auto_crossover_p1,
  output logic            auto_crossover_p2,
  output logic            eeprom_large,
  output logic            mgmt_is_smi,
  output logic            mgmt_is_i2c,
  output logic            mgmt_reserved,
  output logic [4:0]      vphy_addr,
  output logic [4:0]      port1_addr,
  output logic [4:0]      port2_addr,
  output logic [2:0]      port0_mode,
  output logic            port0_phy_mode,
  output logic            port0_rmii,
  output logic            port0_turbo,
  output logic            port0_clk_16ma,
  output logic            port0_clk_in,
  output logic            port0_mode_reserved,
  output logic            port0_full_duplex,
  output logic            straps_valid,
  output logic [5:0]      led_pin_o,
  output logic [5:0]      led_pin_oe
);
  sscd_pkg::sscd_state_e st_q, st_d;
  logic [3:0]  dly_q, dly_d;
  logic        ext_q, ext_d;
  logic [10:0] cfg_q, cfg_d;
  logic [16:0] dec_q, dec_d;
  logic [4:0]  addr_base;
  logic [2:0]  p0_pin;
  logic        dup_pin;
  logic [5:0]  led_straps;
  logic        led_en;

  // Undriven mode inputs resolve to 1 via the internal pull-up
  assign p0_pin  = port0_iface_sel | ~port0_iface_sel_drv;
  assign dup_pin = port0_duplex_polarity_strap
                   | ~port0_duplex_polarity_drv;

  function automatic logic [5:0] p0_flags(input logic [2:0] m);
    // {phy, rmii, turbo, 16mA, clk in, reserved}
    unique case (m)
      `SSCD_P0_MII_MAC:   p0_flags = 6'h00;
      `SSCD_P0_MII_PHY:   p0_flags = 6'h20;
      `SSCD_P0_TURBO_12:  p0_flags = 6'h28;
      `SSCD_P0_TURBO_16:  p0_flags = 6'h2C;
      `SSCD_P0_RMII_12:   p0_flags = 6'h30;
      `SSCD_P0_RMII_16:   p0_flags = 6'h34;
      `SSCD_P0_RMII_CKIN: p0_flags = 6'h32;
      default:            p0_flags = 6'h01;
    endcase
  endfunction

  // Sampling waits a few cycles after either reset lifts so straps settle
  always_comb begin
    st_d  = st_q;
    dly_d = dly_q;
    ext_d = ext_reset_n;
    cfg_d = cfg_q;
    if (!ext_reset_n) begin
      st_d  = sscd_pkg::SSCD_ST_RESET;
      dly_d = 4'h0;
      // Drop valid while held, so stale straps never pass for a new sample
      cfg_d[0] = 1'b0;
    end else begin
      unique case (st_q)
        sscd_pkg::SSCD_ST_RESET: begin
          if (!ext_q) begin
            st_d = sscd_pkg::SSCD_ST_WAIT;
          end
        end
        sscd_pkg::SSCD_ST_WAIT: begin
          dly_d = dly_q + 4'h1;
          if (dly_q == `SSCD_SAMPLE_DLY) begin
            st_d = sscd_pkg::SSCD_ST_SAMPLE;
          end
        end
        sscd_pkg::SSCD_ST_SAMPLE: begin
          cfg_d = {xover_p1_strap, xover_p2_strap, eeprom_size_strap,
                   mgmt_sel_hi, mgmt_sel_lo, port_id_offset_strap,
                   p0_pin, dup_pin, 1'b1};
          st_d  = sscd_pkg::SSCD_ST_RUN;
        end
        sscd_pkg::SSCD_ST_RUN: begin
          // Only an explicit override changes config while running
          if (ovr_we) begin
            cfg_d = {ovr_xover, ovr_eeprom_large, ovr_mgmt, ovr_addr_off,
                     ovr_port0_iface_sel, ovr_dup_pol, 1'b1};
          end
        end
      endcase
    end
  end

  always_comb begin
    logic [5:0] f;
    f = p0_flags(cfg_q[4:2]);
    addr_base = cfg_q[5] ? `SSCD_ADDR_HI : `SSCD_ADDR_LO;
    dec_d[16]    = cfg_q[10];
    dec_d[15]    = cfg_q[9];
    dec_d[14]    = cfg_q[8];
    dec_d[13]    = cfg_q[7:6] == `SSCD_MGMT_SMI;
    dec_d[12]    = cfg_q[7:6] == `SSCD_MGMT_I2C;
    dec_d[11]    = cfg_q[7] == cfg_q[6];
    dec_d[10:5]  = f;
    // Polarity 0: low pin is full duplex; polarity 1: high pin is
    dec_d[4]     = cfg_q[1] ? port0_duplex_pin : ~port0_duplex_pin;
    dec_d[3]     = cfg_q[0];
    dec_d[2:0]   = cfg_q[4:2];
  end

  assign led_straps = {cfg_q[10], cfg_q[9], cfg_q[8],
                       cfg_q[6], cfg_q[7], cfg_q[5]};
  // Standard LED map only; other functions leave the pins released
  assign led_en = cfg_q[0] && st_q == sscd_pkg::SSCD_ST_RUN
                  && led_function_sel == `SSCD_LED_FUNCTION_SEL_STD;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= sscd_pkg::SSCD_ST_WAIT;
      dly_q <= 4'h0;
      ext_q <= 1'b0;
      cfg_q <= {3'h7, `SSCD_RST_MGMT, 1'b0, `SSCD_RST_PORT0_IFACE_SEL,
                `SSCD_RST_DUP_POL, 1'b0};
      dec_q <= 17'h0;
    end else if (clk_en) begin
      st_q  <= st_d;
      dly_q <= dly_d;
      ext_q <= ext_d;
      cfg_q <= cfg_d;
      dec_q <= dec_d;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_led
      sscd_led_drive u_led (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .drive_en  (led_en),
        .strap_val (led_straps[i]),
        .led_on    (led_status[i]),
        .pin_o     (led_pin_o[i]),
        .pin_oe    (led_pin_oe[i])
      );
    end
  endgenerate

  logic [4:0] a0_q, a1_q, a2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      a0_q <= 5'h00;
      a1_q <= 5'h00;
      a2_q <= 5'h00;
    end else if (clk_en) begin
      a0_q <= addr_base;
      a1_q <= 5'(addr_base + 5'h01);
      a2_q <= 5'(addr_base + 5'h02);
    end
  end

  assign auto_crossover_p1   = dec_q[16];
  assign auto_crossover_p2   = dec_q[15];
  assign eeprom_large        = dec_q[14];
  assign mgmt_is_smi         = dec_q[13];
  assign mgmt_is_i2c         = dec_q[12];
  assign mgmt_reserved       = dec_q[11];
  assign port0_phy_mode      = dec_q[10];
  assign port0_rmii          = dec_q[9];
  assign port0_turbo         = dec_q[8];
  assign port0_clk_16ma      = dec_q[7];
  assign port0_clk_in        = dec_q[6];
  assign port0_mode_reserved = dec_q[5];
  assign port0_full_duplex   = dec_q[4];
  assign straps_valid        = dec_q[3];
  assign port0_mode          = dec_q[2:0];
  assign vphy_addr           = a0_q;
  assign port1_addr          = a1_q;
  assign port2_addr          = a2_q;
endmodule

// *** shared/sscd_params.svh ***
`ifndef SSCD_PARAMS_SVH
`define SSCD_PARAMS_SVH
// Management select codes, high bit first
`define SSCD_MGMT_SMI      2'h1
`define SSCD_MGMT_I2C      2'h2
// Port 0 interface codes
`define SSCD_P0_MII_MAC    3'h0
`define SSCD_P0_MII_PHY    3'h1
`define SSCD_P0_TURBO_12   3'h2
`define SSCD_P0_TURBO_16   3'h3
`define SSCD_P0_RMII_12    3'h4
`define SSCD_P0_RMII_16    3'h5
`define SSCD_P0_RMII_CKIN  3'h6
// Reset values of latched straps
`define SSCD_RST_MGMT      2'h2
`define SSCD_RST_PORT0_IFACE_SEL   3'h7
`define SSCD_RST_DUP_POL   1'h1
`define SSCD_RST_BIT       1'h1
// LED function select values
`define SSCD_LED_FUNCTION_SEL_STD   2'h0
// PHY address bases
`define SSCD_ADDR_LO       5'h00
`define SSCD_ADDR_HI       5'h01
// Final wait count after reset release; the wait lasts this plus one cycles before straps are taken
`define SSCD_SAMPLE_DLY    4'h3
`endif

// *** shared/sscd_pkg.sv ***
package sscd_pkg;
  typedef enum logic [1:0] {
    SSCD_MGMT_RSV0 = 2'b00,
    SSCD_MGMT_SMI  = 2'b01,
    SSCD_MGMT_I2C  = 2'b10,
    SSCD_MGMT_RSV3 = 2'b11
  } sscd_mgmt_e;

  typedef enum logic [1:0] {
    SSCD_ST_RESET  = 2'b00,
    SSCD_ST_WAIT   = 2'b01,
    SSCD_ST_SAMPLE = 2'b10,
    SSCD_ST_RUN    = 2'b11
  } sscd_state_e;

  typedef logic [2:0] sscd_port0_iface_sel_t;
endpackage

// *** test/sscd_board.sv ***
module sscd_board (
  input  wire logic [5:0] jumper,
  input  wire logic [3:0] sw_closed,
  input  wire logic       button,
  output logic            xover_p1_strap,
  output logic            xover_p2_strap,
  output logic            eeprom_size_strap,
  output logic            mgmt_sel_lo,
  output logic            mgmt_sel_hi,
  output logic            port_id_offset_strap,
  output logic [2:0]      port0_iface_sel,
  output logic [2:0]      port0_iface_sel_drv,
  output logic            port0_duplex_polarity_strap,
  output logic            port0_duplex_polarity_drv,
  output logic            ext_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  assign {xover_p1_strap, xover_p2_strap, eeprom_size_strap, mgmt_sel_lo,
          mgmt_sel_hi, port_id_offset_strap} = jumper;
  // Open switches float; show 0 so only the internal pull-up can give 1
  assign {port0_duplex_polarity_strap, port0_iface_sel} = 4'h0;
  assign {port0_duplex_polarity_drv, port0_iface_sel_drv} = sw_closed;
  assign ext_reset_n = !button;
endmodule

// *** test/sscd_strap_decode_asserts.sv ***
module sscd_strap_decode_asserts (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       ext_reset_n,
  input wire logic       ovr_we,
  input wire logic [2:0] ovr_port0_iface_sel,
  input wire logic [1:0] led_function_sel,
  input wire logic [5:0] led_status,
  input wire logic       mgmt_is_smi,
  input wire logic       mgmt_is_i2c,
  input wire logic       mgmt_reserved,
  input wire logic [4:0] vphy_addr,
  input wire logic [4:0] port1_addr,
  input wire logic [4:0] port2_addr,
  input wire logic [2:0] port0_mode,
  input wire logic       port0_clk_in,
  input wire logic       auto_crossover_p1,
  input wire logic       straps_valid,
  input wire logic [5:0] led_pin_o,
  input wire logic [5:0] led_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet; !straps_valid [*4]; endsequence
  sequence s_load; ##[1:8] straps_valid; endsequence
  mgmt_onehot_a: assert property (straps_valid |->
    $onehot({mgmt_is_smi, mgmt_is_i2c, mgmt_reserved})) else $error("mgmt");
  addr_base_a: assert property (straps_valid |-> vphy_addr <= 5'h01 &&
    port1_addr == vphy_addr + 5'h01 && port2_addr == vphy_addr + 5'h02)
    else $error("port addresses");
  mode_decode_a: assert property (straps_valid |->
    port0_clk_in == (port0_mode == 3'h6)) else $error("clock input mode");
  config_hold_a: assert property (straps_valid && $past(straps_valid) &&
    $past(ext_reset_n) && $past(ext_reset_n, 2) && !$past(ovr_we) &&
    !$past(ovr_we, 2) |-> $stable(port0_mode) && $stable(vphy_addr))
    else $error("latched config moved");
  led_level_a: assert property (led_pin_oe[5] && $stable(led_status) |->
    led_pin_o[5] == (led_status[5] ^ auto_crossover_p1)) else $error("led");
  led_release_a: assert property ($past(led_function_sel) != 2'h0 &&
    $past(led_function_sel, 2) != 2'h0 |-> led_pin_oe == 6'h00)
    else $error("led pins driven");
  reset_hold_a: assert property (!ext_reset_n [*3] |-> !straps_valid)
    else $error("valid during reset");
  resample_a: assert property ($rose(ext_reset_n) |=> s_quiet ##0 s_load)
    else $error("resample timing");
  override_a: assert property (straps_valid && ovr_we && ext_reset_n &&
    $past(ext_reset_n) |-> ##2 port0_mode == $past(ovr_port0_iface_sel, 2))
    else $error("override lost");
endmodule

bind sscd_strap_decode sscd_strap_decode_asserts u_chk (.*);

// *** test/sscd_strap_decode_test.sv ***
module sscd_strap_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_n = 0, button = 0, port0_duplex_pin = 0, clk_en = 1;
  logic ovr_we = 0, ovr_eeprom_large = 0, ovr_addr_off = 0, ovr_dup_pol = 0;
  logic [1:0] ovr_xover = '0, ovr_mgmt = '0, led_function_sel = '0;
  logic [2:0] ovr_port0_iface_sel = '0, m, port0_iface_sel, port0_iface_sel_drv;
  logic [3:0] sw_closed = '0, s;
  logic [5:0] jumper = '0, led_status = '0, j, led_pin_o, led_pin_oe;
  logic [4:0] vphy_addr, port1_addr, port2_addr;
  logic [2:0] port0_mode;
  logic xover_p1_strap, xover_p2_strap, eeprom_size_strap, mgmt_sel_lo;
  logic mgmt_sel_hi, port_id_offset_strap, ext_reset_n, straps_valid;
  logic port0_duplex_polarity_strap, port0_duplex_polarity_drv;
  logic auto_crossover_p1, auto_crossover_p2, eeprom_large, mgmt_is_smi;
  logic mgmt_is_i2c, mgmt_reserved, port0_phy_mode, port0_rmii, port0_turbo;
  logic port0_clk_16ma, port0_clk_in, port0_mode_reserved, port0_full_duplex;
  int   fail_count = 0, checked = 0;
  sscd_board board (.*);
  sscd_strap_decode uut (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Bounded wait, then two spare cycles so the LED drivers have settled
  task automatic wait_valid;
    int n = 0;
    do @(negedge sys_clk); while (straps_valid !== 1'b1 && ++n < 40);
    check(n < 40, 16'h1);
    repeat (2) @(negedge sys_clk);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_valid();
    check(port0_mode, 16'h7);
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      j = {m[1], m[2], m[0] ^ m[1], m[0], m[1], m[0]};
      s = {m[0], ~m};
      @(posedge sys_clk);
      {jumper, sw_closed, button} <= {j, s, 1'b1};
      {led_status, port0_duplex_pin} <= {m, ~m, m[1]};
      repeat (3) @(posedge sys_clk);
      button <= 1'b0;
      wait_valid();
      check(port0_mode, m);
      check({port0_phy_mode, port0_rmii, port0_turbo, port0_clk_16ma,
             port0_clk_in, port0_mode_reserved},
            {m inside {[1:6]}, m inside {[4:6]}, m[2:1] == 2'h1,
             m == 3'h3 || m == 3'h5, m == 3'h6, m == 3'h7});
      check({mgmt_is_smi, mgmt_is_i2c, mgmt_reserved},
            {m[1:0] == 2'h1, m[1:0] == 2'h2, m[1] == m[0]});
      check({vphy_addr, port1_addr, port2_addr},
            m[0] ? {5'h01, 5'h02, 5'h03} : {5'h00, 5'h01, 5'h02});
      check({auto_crossover_p1, auto_crossover_p2, eeprom_large},
            j[5:3]);
      check(port0_full_duplex, m[1] ^ m[0]);
      check(led_pin_oe, 6'h3F);
      check(led_pin_o, {m, ~m} ^ j);
      // Straps moved without a reset must not reach the outputs
      @(posedge sys_clk);
      {jumper, sw_closed} <= {~j, ~s};
      repeat (12) @(negedge sys_clk);
      check({port0_mode, eeprom_large}, {m, j[3]});
    end
    @(posedge sys_clk);
    {ovr_xover, ovr_port0_iface_sel, ovr_mgmt, ovr_we} <= {2'h3, 3'h4, 2'h1, 1'h1};
    @(posedge sys_clk);
    {ovr_we, led_function_sel} <= {1'h0, 2'h1};
    repeat (4) @(negedge sys_clk);
    check({port0_mode, mgmt_is_smi, port0_rmii}, 16'h13);
    check(led_pin_oe, 6'h00);
    summarize();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end
endmodule
